// ===== roc_osc_ctrl.sv
// Operation
// R1 - Data port moves bytes to selected register
// R2 - Software avoids read-modify-write on data port
// R3 - Oscillator timebase crosses into system clock
// R4 - Crystal or self-oscillate mode supported
// R5 - Mode bit one selects crystal
// R6 - Software crystal start sequence, wait 20ms
// R7 - Software polls valid, ready, then tunes
// R8 - CMOS clock: lowest bias, check fail
// R9 - Bias double picks 20 or 40kHz
// R10 - Self-oscillate starts without wait
// R11 - Sixteen load settings in four bits
// R12 - Auto stepping rises from smallest setting
// R13 - Ready flag sets at final setting
// R14 - Load code maps to capacitance table
// R15 - Larger load lowers self-oscillate frequency
// R16 - Pin short control joins oscillator pins
// R17 - Busy write starts indirect read
// R18 - Bias double is control bit five
// R19 - New load value clears ready flag
// R20 - Stepping advances per oscillator interval
`timescale 1ns/10ps
`default_nettype none
module roc_osc_ctrl #(
    parameter int STEP_OSC_CYCLES = roc_pkg::ROC_STEP_OSC_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic osc_clk_in,
    input wire logic xtal_valid_in,
    output logic [7:0] sfr_rdata_out,
    output roc_pkg::roc_analog_s analog_out,
    output logic [7:0] cap_tenth_pf_out
);
    // ----------------------------------------------------------------
    // Synchronisers for the oscillator timebase and analog detector
    // ----------------------------------------------------------------
    logic [1:0] osc_sync;
    logic osc_last;
    logic [1:0] valid_sync;
    logic osc_edge;

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            osc_sync <= 2'h0;
            osc_last <= 1'b0;
            valid_sync <= 2'h0;
        end else begin
            osc_sync <= {osc_sync[0], osc_clk_in}; // see R3
            osc_last <= osc_sync[1];
            valid_sync <= {valid_sync[0], xtal_valid_in};
        end
    end

    assign osc_edge = osc_sync[1] & ~osc_last; // see R3

    // ----------------------------------------------------------------
    // Index select and data port
    // ----------------------------------------------------------------
    logic [3:0] index_sel;
    logic busy;
    logic [7:0] data_port;
    logic wr_index;
    logic wr_data;
    logic [7:0] indirect_value;
    logic power;
    logic gain;
    logic bias_double;
    logic xtal_mode;
    logic auto_step;
    logic [3:0] cap_final;
    logic [3:0] cap_applied;
    logic load_ready;
    logic pin_short;

    assign wr_index = sfr_wr_in && (sfr_addr_in == roc_pkg::ROC_ADDR_INDEX_SELECT);
    assign wr_data = sfr_wr_in && (sfr_addr_in == roc_pkg::ROC_ADDR_DATA_PORT);

    always_comb begin
        indirect_value = 8'h00;
        unique case (index_sel)
            roc_pkg::ROC_IDX_OSC_CONTROL: begin
                indirect_value[roc_pkg::ROC_BIT_POWER] = power;
                indirect_value[roc_pkg::ROC_BIT_GAIN] = gain;
                indirect_value[roc_pkg::ROC_BIT_BIAS_DOUBLE] = bias_double;
                indirect_value[roc_pkg::ROC_BIT_XTAL_VALID] = valid_sync[1];
                indirect_value[roc_pkg::ROC_BIT_XTAL_MODE] = xtal_mode;
            end
            roc_pkg::ROC_IDX_LOAD_CAP: begin
                indirect_value[roc_pkg::ROC_BIT_AUTO_STEP] = auto_step;
                indirect_value[roc_pkg::ROC_BIT_LOAD_READY] = load_ready;
                indirect_value[3:0] = cap_final;
            end
            roc_pkg::ROC_IDX_PIN_SHORT: begin
                indirect_value[roc_pkg::ROC_BIT_PIN_SHORT] = pin_short;
            end
            default: begin
                indirect_value = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            index_sel <= 4'h0;
            busy <= 1'b0;
        end else if (wr_index) begin
            index_sel <= sfr_wdata_in[3:0];
            busy <= sfr_wdata_in[roc_pkg::ROC_BIT_BUSY]; // see R17
        end else begin
            busy <= 1'b0;
        end
    end

    // A data port write or a busy index write transfers; a read just returns the port latch, not the selected register
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            data_port <= roc_pkg::ROC_DATA_RESET;
        end else if (wr_data) begin
            data_port <= sfr_wdata_in; // see R1
        end else if (busy) begin
            data_port <= indirect_value; // see R17
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in && sfr_addr_in == roc_pkg::ROC_ADDR_INDEX_SELECT) begin
            sfr_rdata_out <= {busy, 3'h0, index_sel};
        end else if (sfr_rd_in && sfr_addr_in == roc_pkg::ROC_ADDR_DATA_PORT) begin
            sfr_rdata_out <= data_port; // see R1
        end else begin
            sfr_rdata_out <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Indirect control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            power <= 1'b0;
            gain <= 1'b0;
            bias_double <= 1'b0;
            xtal_mode <= 1'b0;
            pin_short <= 1'b0;
        end else if (wr_data && index_sel == roc_pkg::ROC_IDX_OSC_CONTROL) begin
            power <= sfr_wdata_in[roc_pkg::ROC_BIT_POWER];
            gain <= sfr_wdata_in[roc_pkg::ROC_BIT_GAIN];
            bias_double <= sfr_wdata_in[roc_pkg::ROC_BIT_BIAS_DOUBLE]; // see R18
            xtal_mode <= sfr_wdata_in[roc_pkg::ROC_BIT_XTAL_MODE]; // see R5
        end else if (wr_data && index_sel == roc_pkg::ROC_IDX_PIN_SHORT) begin
            pin_short <= sfr_wdata_in[roc_pkg::ROC_BIT_PIN_SHORT]; // see R16
        end
    end

    // ----------------------------------------------------------------
    // Load capacitance stepping
    // ----------------------------------------------------------------
    roc_pkg::roc_step_e step_state;
    logic [$clog2(STEP_OSC_CYCLES + 1)-1:0] step_count;
    logic wr_cap;

    assign wr_cap = wr_data && index_sel == roc_pkg::ROC_IDX_LOAD_CAP;

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            auto_step <= 1'b0;
            cap_final <= roc_pkg::ROC_CAP_MIN;
        end else if (wr_cap) begin
            auto_step <= sfr_wdata_in[roc_pkg::ROC_BIT_AUTO_STEP];
            cap_final <= sfr_wdata_in[3:0]; // see R11
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            step_state <= roc_pkg::ROC_STEP_IDLE;
            cap_applied <= roc_pkg::ROC_CAP_MIN;
            step_count <= '0;
            load_ready <= 1'b0;
        end else if (wr_cap) begin
            load_ready <= 1'b0; // see R19
            step_count <= '0;
            step_state <= roc_pkg::ROC_STEP_RUN;
            if (sfr_wdata_in[roc_pkg::ROC_BIT_AUTO_STEP]) begin
                cap_applied <= roc_pkg::ROC_CAP_MIN; // see R12
            end else begin
                cap_applied <= sfr_wdata_in[3:0];
            end
        end else begin
            unique case (step_state)
                roc_pkg::ROC_STEP_IDLE: begin
                    step_count <= '0;
                end
                roc_pkg::ROC_STEP_RUN: begin
                    if (cap_applied == cap_final) begin
                        load_ready <= 1'b1; // see R13
                        step_state <= roc_pkg::ROC_STEP_IDLE;
                    end else if (osc_edge) begin
                        if (step_count == ($bits(step_count))'(STEP_OSC_CYCLES - 1)) begin
                            step_count <= '0;
                            cap_applied <= cap_applied + 4'h1; // see R20
                        end else begin
                            step_count <= step_count + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Analog controls
    // ----------------------------------------------------------------
    // Mode, bias and load drive the oscillator directly: self-oscillate
    // needs no start wait, and a larger load code lowers its frequency
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            analog_out <= '0;
        end else begin
            analog_out.power <= power; // see R10
            analog_out.gain <= gain & xtal_mode; // see R4
            analog_out.bias_double <= bias_double; // see R9
            analog_out.xtal_mode <= xtal_mode; // see R5
            analog_out.pin_short <= pin_short; // see R16
            analog_out.cap_applied <= cap_applied; // see R15
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            cap_tenth_pf_out <= roc_pkg::ROC_CAP_BASE_TENTH;
        end else if (cap_applied <= roc_pkg::ROC_CAP_FINE_LAST) begin
            cap_tenth_pf_out <= roc_pkg::ROC_CAP_BASE_TENTH
                + 8'(cap_applied * roc_pkg::ROC_CAP_FINE_TENTH); // see R14
        end else begin
            cap_tenth_pf_out <= roc_pkg::ROC_CAP_COARSE_BASE
                + 8'((cap_applied - roc_pkg::ROC_CAP_FINE_LAST)
                * roc_pkg::ROC_CAP_COARSE_TENTH); // see R14
        end
    end
endmodule : roc_osc_ctrl
`default_nettype wire

// ===== roc_pkg.sv
package roc_pkg;
    // Special function register addresses
    localparam logic [7:0] ROC_ADDR_INDEX_SELECT = 8'hac;
    localparam logic [7:0] ROC_ADDR_DATA_PORT = 8'had;
    localparam logic [7:0] ROC_DATA_RESET = 8'h00;

    // Indirect register indices
    localparam logic [3:0] ROC_IDX_OSC_CONTROL = 4'h6;
    localparam logic [3:0] ROC_IDX_LOAD_CAP = 4'h7;
    localparam logic [3:0] ROC_IDX_PIN_SHORT = 4'h8;

    // Index select fields
    localparam int ROC_BIT_BUSY = 7;

    // Oscillator control fields
    localparam int ROC_BIT_POWER = 7;
    localparam int ROC_BIT_GAIN = 6;
    localparam int ROC_BIT_BIAS_DOUBLE = 5;
    localparam int ROC_BIT_XTAL_VALID = 4;
    localparam int ROC_BIT_XTAL_MODE = 3;

    // Load capacitance and pin short fields
    localparam int ROC_BIT_AUTO_STEP = 7;
    localparam int ROC_BIT_LOAD_READY = 6;
    localparam int ROC_BIT_PIN_SHORT = 0;

    localparam logic [3:0] ROC_CAP_MIN = 4'h0;
    localparam logic [3:0] ROC_CAP_FINE_LAST = 4'hb;
    // Load capacitance in tenths of a pF
    localparam logic [7:0] ROC_CAP_BASE_TENTH = 8'h28;
    localparam logic [7:0] ROC_CAP_FINE_TENTH = 8'h05;
    localparam logic [7:0] ROC_CAP_COARSE_BASE = 8'h5f;
    localparam logic [7:0] ROC_CAP_COARSE_TENTH = 8'h0a;

    // Oscillator edges per capacitance step
    localparam int ROC_STEP_OSC_CYCLES = 64;

    typedef enum logic [0:0] {
        ROC_STEP_IDLE = 1'b0,
        ROC_STEP_RUN = 1'b1
    } roc_step_e;

    typedef struct packed {
        logic power;
        logic gain;
        logic bias_double;
        logic xtal_mode;
        logic pin_short;
        logic [3:0] cap_applied;
    } roc_analog_s;
endpackage : roc_pkg

// ===== roc_osc_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module roc_osc_ctrl_asserts #(
    parameter int STEP_OSC_CYCLES = 64
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic osc_clk_in,
    input wire logic xtal_valid_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire roc_pkg::roc_analog_s analog_out,
    input wire logic [7:0] cap_tenth_pf_out
);
    logic [3:0] idx;
    logic [7:0] sh;
    logic shv;
    wire dw = sfr_wr_in && sfr_addr_in == 8'had;
    wire iw = sfr_wr_in && sfr_addr_in == 8'hac;
    // ------------
    // Shadow state
    // ------------
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            idx <= 4'h0;
        end else if (iw) begin
            idx <= sfr_wdata_in[3:0];
        end
    end
    // A busy read reloads the port, so the shadow is only trusted after a plain write
    always_ff @(posedge clock_in) begin
        if (!reset_n_in || iw) begin
            shv <= 1'b0;
        end else if (dw) begin
            shv <= 1'b1;
        end
    end
    always_ff @(posedge clock_in) begin
        if (dw) begin
            sh <= sfr_wdata_in;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    a_rdata_idle: assert property (!sfr_rd_in |=> sfr_rdata_out == 8'h00)
        else $error("read data not zero when idle");
    a_unmapped_rd: assert property (
        sfr_rd_in && sfr_addr_in != 8'hac && sfr_addr_in != 8'had |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_index_rb: assert property (
        sfr_rd_in && sfr_addr_in == 8'hac |=> sfr_rdata_out[6:0] == {3'h0, idx})
        else $error("index select readback wrong");
    a_dport_rb: assert property (
        sfr_rd_in && sfr_addr_in == 8'had && shv |=> sfr_rdata_out == sh)
        else $error("data port readback wrong");
    a_ctrl_bits: assert property (dw && idx == 4'h6 |=> ##2 analog_out.power == sh[7]
        && analog_out.bias_double == sh[5] && analog_out.xtal_mode == sh[3])
        else $error("oscillator control not applied");
    a_gain_self: assert property (!analog_out.xtal_mode |-> !analog_out.gain)
        else $error("gain on in self-oscillate mode");
    a_cap_range: assert property (
        cap_tenth_pf_out >= 8'h28 && cap_tenth_pf_out <= 8'h87)
        else $error("load capacitance out of range");
    a_cap_rise: assert property (
        !$past(sfr_wr_in) && !$past(sfr_wr_in, 2) && !$past(sfr_wr_in, 3) && !$past(sfr_wr_in, 4)
        |-> analog_out.cap_applied >= $past(analog_out.cap_applied))
        else $error("load capacitance fell without a write");
endmodule : roc_osc_ctrl_asserts
bind roc_osc_ctrl roc_osc_ctrl_asserts #(.STEP_OSC_CYCLES(STEP_OSC_CYCLES)) u_chk (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .osc_clk_in(osc_clk_in), .xtal_valid_in(xtal_valid_in), .sfr_rdata_out(sfr_rdata_out),
    .analog_out(analog_out), .cap_tenth_pf_out(cap_tenth_pf_out));
`default_nettype wire

// ===== roc_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module roc_cpu_model (
    input wire logic clock_in,
    output logic [7:0] sfr_addr_out,
    output logic [7:0] sfr_wdata_out,
    output logic sfr_wr_out,
    output logic sfr_rd_out,
    input wire logic [7:0] sfr_rdata_in
);
    initial begin
        {sfr_addr_out, sfr_wdata_out, sfr_wr_out, sfr_rd_out} = 18'h00000;
    end
    // ------------
    // Bus cycles
    // ------------
    // Plain stores only, never read-modify-write; lines scrambled after each cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        sfr_addr_out = a;
        sfr_wdata_out = d;
        sfr_wr_out = 1'b1;
        @(negedge clock_in);
        sfr_wr_out = 1'b0;
        sfr_addr_out = ~a;
        sfr_wdata_out = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_in);
        sfr_addr_out = a;
        sfr_rd_out = 1'b1;
        @(negedge clock_in);
        sfr_rd_out = 1'b0;
        sfr_addr_out = ~a;
        d = sfr_rdata_in;
    endtask : rd
endmodule : roc_cpu_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
    logic clock_in, reset_n_in, osc_clk_in, xtal_valid_in, sfr_wr_in, sfr_rd_in;
    logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, cap_tenth_pf_out, r;
    roc_pkg::roc_analog_s an;
    int seed, error_cnt, total_checks, code;
    roc_osc_ctrl #(.STEP_OSC_CYCLES(2)) dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
        .sfr_rd_in(sfr_rd_in), .osc_clk_in(osc_clk_in), .xtal_valid_in(xtal_valid_in),
        .sfr_rdata_out(sfr_rdata_out), .analog_out(an), .cap_tenth_pf_out(cap_tenth_pf_out));
    roc_cpu_model cpu (.clock_in(clock_in), .sfr_addr_out(sfr_addr_in),
        .sfr_wdata_out(sfr_wdata_in), .sfr_wr_out(sfr_wr_in), .sfr_rd_out(sfr_rd_in),
        .sfr_rdata_in(sfr_rdata_out));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // Slow timebase, unrelated in phase to the system clock
    initial begin
        osc_clk_in = 1'b0;
        forever #37 osc_clk_in = ~osc_clk_in;
    end
    // ------------
    // Model
    // ------------
    function automatic logic [7:0] tenth(input int c);
        return (c <= 11) ? 8'(40 + 5 * c) : 8'(95 + 10 * (c - 11));
    endfunction : tenth
    task automatic iwrite(input logic [3:0] i, input logic [7:0] d);
        cpu.wr(8'hac, {4'h0, i});
        cpu.wr(8'had, d);
        repeat (4) @(negedge clock_in);
    endtask : iwrite
    task automatic iread(input logic [3:0] i, output logic [7:0] d);
        cpu.wr(8'hac, {4'h8, i});
        cpu.rd(8'had, d);
    endtask : iread
    task automatic step_to(input int c);
        int prev;
        prev = 0;
        for (int n = 0; n < 3000 && int'(an.cap_applied) != c; n++) begin
            @(negedge clock_in);
            `CHK(int'(an.cap_applied) - prev <= 1, 1'b1)
            prev = int'(an.cap_applied);
        end
        if (int'(an.cap_applied) != c) begin
            error_cnt++;
            print_verdict();
        end
    endtask : step_to
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        seed = 32'h06cabc00;
        error_cnt = 0;
        total_checks = 0;
        reset_n_in = 1'b0;
        xtal_valid_in = 1'b1;
        repeat (12) @(negedge clock_in);
        reset_n_in = 1'b1;
        `CHK(cap_tenth_pf_out, 8'h28)
        cpu.wr(8'hae, 8'h5a);
        cpu.rd(8'hae, r);
        `CHK(r, 8'h00)
        cpu.rd(8'had, r);
        `CHK(r, 8'h00)
        $display("reset test done");
        iwrite(4'h6, 8'h28);
        iwrite(4'h7, 8'h05);
        iwrite(4'h6, 8'ha8);
        `CHK(an, 9'h165)
        cpu.rd(8'had, r);
        `CHK(r, 8'ha8)
        iread(4'h6, r);
        `CHK(r, 8'hb8)
        cpu.rd(8'hac, r);
        `CHK(r, 8'h06)
        iread(4'h7, r);
        `CHK(r, 8'h45)
        iwrite(4'h6, 8'hc8);
        `CHK(an, 9'h1a5)
        // External clock: valid detector output is meaningless, lowest bias
        xtal_valid_in = 1'b0;
        iwrite(4'h6, 8'h88);
        `CHK(an, 9'h125)
        iread(4'h6, r);
        `CHK(r, 8'h88)
        for (int b = 0; b < 2; b++) begin
            iwrite(4'h6, 8'(8'hc0 + 32 * b));
            `CHK(an, 9'(9'h105 + 64 * b))
        end
        iwrite(4'h8, 8'h01);
        `CHK(an.pin_short, 1'b1)
        $display("mode test done");
        for (int c = 0; c < 16; c++) begin
            iwrite(4'h7, 8'(c));
            `CHK(cap_tenth_pf_out, tenth(c))
            iread(4'h7, r);
            `CHK(r, 8'(c + 64))
        end
        $display("load code test done");
        for (int k = 0; k < 3; k++) begin
            code = 8 + int'($unsigned($random(seed)) % 8);
            iwrite(4'h7, 8'(code + 128));
            `CHK(an.cap_applied, 4'h0)
            iread(4'h7, r);
            `CHK(r[6], 1'b0)
            step_to(code);
            repeat (40) @(negedge clock_in);
            `CHK(an.cap_applied, 4'(code))
            `CHK(cap_tenth_pf_out, tenth(code))
            iread(4'h7, r);
            `CHK(r, 8'(code + 192))
        end
        $display("auto step test done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
